// File: design/rail_sequencer.sv
// One output's power-on delay, ramp and power-off delay sequencer.
module rail_sequencer (
  input wire logic core_clk_i, // 100 MHz clock
  input wire logic rst_b_i, // async reset, active low
  input wire logic ce_i, // clock enable
  input supply_limit_pkg::rail_cfg_s cfg_i, // delays, rise, target
  input wire logic enable_i, // output enable request
  input wire logic lockout_i, // input undervoltage lockout
  output supply_limit_pkg::rail_stat_s stat_o // state and ramp reference
);

  supply_limit_pkg::rail_state_e state;
  supply_limit_pkg::rail_state_e next_state;
  // Ten bits hold the 1000 cycles of one 10 us step.
  logic [9:0] cyc_cnt;
  logic [15:0] step_cnt;
  logic [31:0] acc;
  logic [15:0] ramp_ref;

  wire go = enable_i & ~lockout_i;
  wire step_end = (cyc_cnt == 10'(supply_limit_pkg::CYCLES_PER_STEP - 1));
  wire on_done = (step_cnt >= cfg_i.on_delay);
  wire off_done = (step_cnt >= cfg_i.off_delay);
  // Cycles of the whole ramp; the ramp rises at most 1 mV per cycle, or jumps to the target when span is zero.
  wire [31:0] span = 32'(cfg_i.rise_time)
    * 32'(supply_limit_pkg::CYCLES_PER_US);
  wire [31:0] acc_sum = acc + 32'(cfg_i.vout_target);
  wire ramp_done = (ramp_ref >= cfg_i.vout_target);
  wire in_delay = (state == supply_limit_pkg::RAIL_ON_DELAY)
    | (state == supply_limit_pkg::RAIL_OFF_DELAY);

  always_comb begin
    next_state = state;
    case (state)
      supply_limit_pkg::RAIL_OFF: begin
        if (go) next_state = supply_limit_pkg::RAIL_ON_DELAY;
      end
      supply_limit_pkg::RAIL_ON_DELAY: begin
        if (!go) next_state = supply_limit_pkg::RAIL_OFF;
        else if (on_done) next_state = supply_limit_pkg::RAIL_RAMP; // RULE13
      end
      supply_limit_pkg::RAIL_RAMP: begin
        if (!go) next_state = supply_limit_pkg::RAIL_OFF_DELAY;
        else if (ramp_done) next_state = supply_limit_pkg::RAIL_ON;
      end
      supply_limit_pkg::RAIL_ON: begin
        if (!go) next_state = supply_limit_pkg::RAIL_OFF_DELAY;
      end
      supply_limit_pkg::RAIL_OFF_DELAY: begin
        if (off_done) next_state = supply_limit_pkg::RAIL_OFF; // RULE13
      end
      default: next_state = supply_limit_pkg::RAIL_OFF;
    endcase
  end

  // Delays are counted in 10 us steps of CYCLES_PER_STEP cycles.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cyc_cnt <= 10'h000;
      step_cnt <= 16'h0000;
    end else if (ce_i) begin
      if (!in_delay || next_state != state) begin
        cyc_cnt <= 10'h000;
        step_cnt <= 16'h0000;
      end else if (step_end) begin
        cyc_cnt <= 10'h000;
        step_cnt <= step_cnt + 16'h0001; // RULE6 RULE10
      end else begin
        cyc_cnt <= cyc_cnt + 10'h001;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= supply_limit_pkg::RAIL_OFF;
      acc <= 32'h00000000;
      ramp_ref <= 16'h0000;
    end else if (ce_i) begin
      state <= next_state;
      if (state != supply_limit_pkg::RAIL_RAMP) begin
        acc <= 32'h00000000;
        if (state == supply_limit_pkg::RAIL_OFF) ramp_ref <= 16'h0000;
      end else if (span == 32'h00000000) begin
        ramp_ref <= cfg_i.vout_target; // RULE8
      end else if (!ramp_done && acc_sum >= span) begin
        acc <= acc_sum - span; // RULE8 RULE9
        ramp_ref <= ramp_ref + 16'h0001;
      end else if (!ramp_done) begin
        acc <= acc_sum;
      end
    end
  end

  assign stat_o.state = state;
  assign stat_o.on = (state != supply_limit_pkg::RAIL_OFF);
  assign stat_o.ramp_ref = ramp_ref;

endmodule : rail_sequencer

// File: design/supply_limit_pkg.sv
// Package of constants and types for the supply limit and sequencing bank.
package supply_limit_pkg;

  localparam int NUM_OUTPUTS = 2;
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_US = 1000;
  localparam int CYCLES_PER_US = NS_PER_US / CLK_PERIOD_NS;

  // Register indexes; the byte address is four times the index.
  localparam logic [7:0] IDX_UV_THRESH = 8'h59;
  localparam logic [7:0] IDX_OC_THRESH = 8'h5b;
  localparam logic [7:0] IDX_ON_DELAY = 8'h60;
  localparam logic [7:0] IDX_RISE_TIME = 8'h61;
  localparam logic [7:0] IDX_OFF_DELAY = 8'h64;
  localparam logic [7:0] IDX_OUTPUT_PAGE = 8'h70;
  localparam logic [7:0] IDX_COMMIT = 8'h71;
  localparam logic [7:0] IDX_CONTROL = 8'h72;
  localparam logic [7:0] IDX_STATUS = 8'h73;
  localparam logic [7:0] IDX_VOUT_TARGET = 8'h74;

  localparam logic [15:0] RST_UV_THRESH = 16'h1f40;
  localparam logic [15:0] RST_OC_THRESH = 16'h0032;
  localparam logic [15:0] RST_ON_DELAY = 16'h0014;
  localparam logic [15:0] RST_RISE_TIME = 16'h01f4;
  localparam logic [15:0] RST_OFF_DELAY = 16'h0000;
  localparam logic [15:0] RST_VOUT_TARGET = 16'h0000;

  // Status field positions.
  localparam int ST_LOCKOUT = 0;
  localparam int ST_OVERCURRENT = 1;
  localparam int ST_PENDING = 2;
  localparam int ST_RAIL_ON_LSB = 4;
  localparam int ST_STATE_LSB = 8;

  // Both delay registers count in steps of 10 us.
  localparam int DELAY_STEP_US = 10;
  localparam int CYCLES_PER_STEP = DELAY_STEP_US * CYCLES_PER_US;

  typedef enum logic [2:0] {
    RAIL_OFF = 3'b000,
    RAIL_ON_DELAY = 3'b001,
    RAIL_RAMP = 3'b010,
    RAIL_ON = 3'b011,
    RAIL_OFF_DELAY = 3'b100
  } rail_state_e;

  typedef struct packed {
    logic [15:0] on_delay;
    logic [15:0] rise_time;
    logic [15:0] off_delay;
    logic [15:0] vout_target;
  } rail_cfg_s;

  typedef struct packed {
    rail_state_e state;
    logic on;
    logic [15:0] ramp_ref;
  } rail_stat_s;

endpackage : supply_limit_pkg

// File: design/supply_limit_sequencing_regs.sv
// Supply limit and sequencing register bank with Avalon-MM slave.
//
// Function
// RULE1: Undervoltage threshold 16 bits, default 8000 mV.
// RULE2: Host keeps undervoltage threshold within 16000 mV.
// RULE3: Input below threshold raises the lockout.
// RULE4: Gated settings wait for the commit command.
// RULE5: Overcurrent threshold 16 bits, default 50 A.
// RULE6: Power-on delay counts 10 us steps.
// RULE7: Host keeps power-on delay 200 to 655340 us.
// RULE8: Rise time in microseconds, default 500.
// RULE9: Ramp rate fixed from target at commit.
// RULE10: Power-off delay counts 10 us steps.
// RULE11: Delays and rise time kept per output.
// RULE12: Undervoltage threshold shared, independent of page.
// RULE13: Ramp after on delay, shutdown after off.
module supply_limit_sequencing_regs (
  input wire logic core_clk_i, // 100 MHz clock
  input wire logic rst_b_i, // async reset, active low
  input wire logic ce_i, // clock enable, freezes state when low
  input wire logic [9:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data, registered
  output logic avs_waitrequest, // high until access completes
  input wire logic [15:0] vin_mv_i, // input voltage, mV
  input wire logic [15:0] iin_a_i, // input current, A
  output logic input_lockout_o, // input undervoltage lockout
  output logic input_overcurrent_o, // input overcurrent flag
  output logic [1:0] rail_on_o, // output sequencing active
  output logic [31:0] ramp_ref_o // two 16-bit ramp references
);

  localparam int N = supply_limit_pkg::NUM_OUTPUTS;

  // Word index match against a register index.
  function automatic logic hit(input logic [9:0] addr,
                               input logic [7:0] idx);
    hit = (addr[9:2] == idx);
  endfunction : hit

  // Byte-lane merge of a 16-bit register with new write data.
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8],
               be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  logic ack;
  logic [31:0] rdata;
  logic page;
  logic [1:0] enable;
  logic pending;
  logic [15:0] uv_pending;
  logic [15:0] uv_active;
  logic [15:0] oc_pending;
  logic [15:0] oc_active;
  logic lockout;
  logic overcurrent;

  wire req = avs_read | avs_write;
  wire wr_fire = avs_write & ack;
  wire rd_take = avs_read & ~ack;

  // One wait cycle: the answer comes in the cycle after the request.
  assign avs_waitrequest = req & ~ack;

  wire wr_uv = wr_fire & hit(avs_address,
    supply_limit_pkg::IDX_UV_THRESH);
  wire wr_oc = wr_fire & hit(avs_address,
    supply_limit_pkg::IDX_OC_THRESH);
  wire wr_on = wr_fire & hit(avs_address,
    supply_limit_pkg::IDX_ON_DELAY);
  wire wr_rise = wr_fire & hit(avs_address,
    supply_limit_pkg::IDX_RISE_TIME);
  wire wr_off = wr_fire & hit(avs_address,
    supply_limit_pkg::IDX_OFF_DELAY);
  wire wr_vout = wr_fire & hit(avs_address,
    supply_limit_pkg::IDX_VOUT_TARGET);
  wire wr_page = wr_fire & hit(avs_address,
    supply_limit_pkg::IDX_OUTPUT_PAGE);
  wire wr_ctrl = wr_fire & hit(avs_address,
    supply_limit_pkg::IDX_CONTROL);
  wire commit = wr_fire & hit(avs_address,
    supply_limit_pkg::IDX_COMMIT);
  wire gated_wr = wr_uv | wr_oc | wr_rise | wr_vout;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack <= 1'b0;
    end else if (ce_i) begin
      ack <= req & ~ack;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      avs_readdata <= 32'h00000000;
    end else if (ce_i && rd_take) begin
      avs_readdata <= rdata;
    end
  end

  // Shared input thresholds, one copy each regardless of page.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      uv_pending <= supply_limit_pkg::RST_UV_THRESH; // RULE1
      oc_pending <= supply_limit_pkg::RST_OC_THRESH; // RULE5
    end else if (ce_i) begin
      if (wr_uv) begin
        uv_pending <= merge16(uv_pending, avs_writedata,
                              avs_byteenable); // RULE12
      end
      if (wr_oc) begin
        oc_pending <= merge16(oc_pending, avs_writedata,
                              avs_byteenable);
      end
    end
  end

  // Old thresholds stay in force until a commit copies the new ones.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      uv_active <= supply_limit_pkg::RST_UV_THRESH; // RULE1
      oc_active <= supply_limit_pkg::RST_OC_THRESH; // RULE5
    end else if (ce_i && commit) begin
      uv_active <= uv_pending; // RULE4
      oc_active <= oc_pending; // RULE4
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pending <= 1'b0;
    end else if (ce_i) begin
      if (commit) pending <= 1'b0;
      else if (gated_wr) pending <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      page <= 1'b0;
      enable <= 2'b00;
    end else if (ce_i) begin
      if (wr_page && avs_byteenable[0]) page <= avs_writedata[0];
      if (wr_ctrl && avs_byteenable[0]) enable <= avs_writedata[1:0];
    end
  end

  // The measurements come from converter logic on this same clock.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lockout <= 1'b1;
      overcurrent <= 1'b0;
    end else if (ce_i) begin
      lockout <= (vin_mv_i < uv_active); // RULE3
      overcurrent <= (iin_a_i > oc_active); // RULE5
    end
  end

  assign input_lockout_o = lockout;
  assign input_overcurrent_o = overcurrent;

  supply_limit_pkg::rail_stat_s stat [N];
  logic [15:0] rd_on [N];
  logic [15:0] rd_rise [N];
  logic [15:0] rd_off [N];
  logic [15:0] rd_vout [N];

  // Per-output copies, reached through the output page.
  for (genvar g = 0; g < N; g++) begin : gen_rail
    logic [15:0] on_delay;
    logic [15:0] off_delay;
    logic [15:0] rise_pending;
    logic [15:0] rise_active;
    logic [15:0] vout_pending;
    logic [15:0] vout_active;
    supply_limit_pkg::rail_cfg_s cfg;

    wire sel = (page == 1'(g)); // RULE11

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        on_delay <= supply_limit_pkg::RST_ON_DELAY; // RULE6
        off_delay <= supply_limit_pkg::RST_OFF_DELAY; // RULE10
      end else if (ce_i && sel) begin
        if (wr_on) begin
          on_delay <= merge16(on_delay, avs_writedata,
                              avs_byteenable); // RULE11
        end
        if (wr_off) begin
          off_delay <= merge16(off_delay, avs_writedata,
                               avs_byteenable); // RULE11
        end
      end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        rise_pending <= supply_limit_pkg::RST_RISE_TIME; // RULE8
        vout_pending <= supply_limit_pkg::RST_VOUT_TARGET;
      end else if (ce_i && sel) begin
        if (wr_rise) begin
          rise_pending <= merge16(rise_pending, avs_writedata,
                                  avs_byteenable);
        end
        if (wr_vout) begin
          vout_pending <= merge16(vout_pending, avs_writedata,
                                  avs_byteenable);
        end
      end
    end

    // Commit applies every page, and the ramp rate follows the
    // target captured here, not later target writes.
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        rise_active <= supply_limit_pkg::RST_RISE_TIME; // RULE8
        vout_active <= supply_limit_pkg::RST_VOUT_TARGET;
      end else if (ce_i && commit) begin
        rise_active <= rise_pending; // RULE4
        vout_active <= vout_pending; // RULE9
      end
    end

    assign cfg.on_delay = on_delay;
    assign cfg.off_delay = off_delay;
    assign cfg.rise_time = rise_active;
    assign cfg.vout_target = vout_active;

    rail_sequencer u_seq (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .cfg_i(cfg),
      .enable_i(enable[g]),
      .lockout_i(lockout), // RULE3
      .stat_o(stat[g])
    );

    assign rd_on[g] = on_delay;
    assign rd_off[g] = off_delay;
    assign rd_rise[g] = rise_pending;
    assign rd_vout[g] = vout_pending;
    assign rail_on_o[g] = stat[g].on;
    assign ramp_ref_o[16*g +: 16] = stat[g].ramp_ref;
  end

  wire [15:0] status_word = {
    5'h00,
    stat[1].state,
    2'h0,
    stat[1].on,
    stat[0].on,
    1'b0,
    pending,
    overcurrent,
    lockout
  };

  wire [15:0] page_on = rd_on[page];
  wire [15:0] page_off = rd_off[page];
  wire [15:0] page_rise = rd_rise[page];
  wire [15:0] page_vout = rd_vout[page];

  // Reads return the last written value; unmapped words read zero.
  wire [15:0] rd16 =
    hit(avs_address, supply_limit_pkg::IDX_UV_THRESH) ? uv_pending :
    hit(avs_address, supply_limit_pkg::IDX_OC_THRESH) ? oc_pending :
    hit(avs_address, supply_limit_pkg::IDX_ON_DELAY) ? page_on :
    hit(avs_address, supply_limit_pkg::IDX_RISE_TIME) ? page_rise :
    hit(avs_address, supply_limit_pkg::IDX_OFF_DELAY) ? page_off :
    hit(avs_address, supply_limit_pkg::IDX_VOUT_TARGET) ? page_vout :
    hit(avs_address, supply_limit_pkg::IDX_OUTPUT_PAGE) ?
      {15'h0000, page} :
    hit(avs_address, supply_limit_pkg::IDX_CONTROL) ?
      {14'h0000, enable} :
    hit(avs_address, supply_limit_pkg::IDX_STATUS) ? status_word :
    16'h0000;

  assign rdata = {16'h0000, rd16};

endmodule : supply_limit_sequencing_regs

// File: verification/host_model.sv
// Management host model that issues register accesses over Avalon-MM.
module host_model (
  input wire logic core_clk_i, // clock
  input wire logic avs_waitrequest, // wait from the bank
  input wire logic [31:0] avs_readdata, // read data
  output logic [9:0] avs_address, // byte address
  output logic avs_read, // read request
  output logic avs_write, // write request
  output logic [31:0] avs_writedata, // write data
  output logic [3:0] avs_byteenable // byte lanes
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    avs_address = 10'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
  end
  task automatic xfer(input logic wr, input logic [7:0] ix,
                      input logic [15:0] d, output logic [15:0] q);
    @(posedge core_clk_i);
    avs_address <= {ix, 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {16'h0, d};
    do @(posedge core_clk_i); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Released lines show the inverse so a stale value cannot pass.
    avs_address <= ~{ix, 2'b00};
    avs_writedata <= ~{16'h0, d};
  endtask : xfer
endmodule : host_model

// File: verification/supply_limit_sequencing_regs_bench.sv
// Self-checking bench of the supply limit and sequencing register bank.
module supply_limit_sequencing_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ce_i = 1'b1;
  logic [15:0] vin_mv_i = 16'h2ee0;
  logic [15:0] iin_a_i = 16'h0;
  logic [9:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, ramp_ref_o;
  logic [3:0] avs_byteenable;
  logic input_lockout_o, input_overcurrent_o;
  logic [1:0] rail_on_o;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  always #5 core_clk_i = ~core_clk_i;
  host_model host_u (.core_clk_i(core_clk_i),
    .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable));
  supply_limit_sequencing_regs dut_u (.core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i), .ce_i(ce_i), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .vin_mv_i(vin_mv_i), .iin_a_i(iin_a_i),
    .input_lockout_o(input_lockout_o),
    .input_overcurrent_o(input_overcurrent_o),
    .rail_on_o(rail_on_o), .ramp_ref_o(ramp_ref_o));
  task stop_test;
    $display("Checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test
  task chk(input string n, input logic [31:0] seen, input logic [31:0] e);
    checked++;
    if (seen !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, seen);
    end
  endtask : chk
  task wr(input logic [7:0] ix, input logic [15:0] d);
    logic [15:0] q;
    host_u.xfer(1'b1, ix, d, q);
  endtask : wr
  task chk_rd(input string n, input logic [7:0] ix, input logic [15:0] e);
    logic [15:0] q;
    host_u.xfer(1'b0, ix, 16'h0, q);
    chk(n, {16'h0, q}, {16'h0, e});
  endtask : chk_rd
  task wait_cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : wait_cyc
  task t_reset;
    chk_rd("uv reset", supply_limit_pkg::IDX_UV_THRESH, 16'h1f40);
    chk_rd("oc reset", supply_limit_pkg::IDX_OC_THRESH, 16'h0032);
    chk_rd("on reset", supply_limit_pkg::IDX_ON_DELAY, 16'h0014);
    chk_rd("rise reset", supply_limit_pkg::IDX_RISE_TIME, 16'h01f4);
    chk_rd("off reset", supply_limit_pkg::IDX_OFF_DELAY, 16'h0);
    chk_rd("unmapped", 8'h10, 16'h0);
  endtask : t_reset
  task t_page;
    wr(supply_limit_pkg::IDX_OUTPUT_PAGE, 16'h1);
    wr(supply_limit_pkg::IDX_ON_DELAY, 16'h0032);
    chk_rd("uv page1", supply_limit_pkg::IDX_UV_THRESH, 16'h1f40);
    wr(supply_limit_pkg::IDX_OUTPUT_PAGE, 16'h0);
    chk_rd("on page0", supply_limit_pkg::IDX_ON_DELAY, 16'h0014);
    wr(supply_limit_pkg::IDX_OUTPUT_PAGE, 16'h1);
    chk_rd("on page1", supply_limit_pkg::IDX_ON_DELAY, 16'h0032);
    wr(supply_limit_pkg::IDX_OUTPUT_PAGE, 16'h0);
  endtask : t_page
  task t_gate;
    vin_mv_i <= 16'h1b58;
    wait_cyc(3);
    chk("lockout 7000", 32'(input_lockout_o), 32'h1);
    wr(supply_limit_pkg::IDX_UV_THRESH, 16'h1770);
    wait_cyc(3);
    chk("lockout pending", 32'(input_lockout_o), 32'h1);
    chk_rd("uv pending", supply_limit_pkg::IDX_UV_THRESH, 16'h1770);
    chk_rd("status pending", supply_limit_pkg::IDX_STATUS, 16'h0005);
    wr(supply_limit_pkg::IDX_COMMIT, 16'h0);
    wait_cyc(3);
    chk("lockout applied", 32'(input_lockout_o), 32'h0);
    // Clock enable low must hold the lockout flop at its old value.
    ce_i <= 1'b0;
    vin_mv_i <= 16'h1388;
    wait_cyc(3);
    chk("lockout frozen", 32'(input_lockout_o), 32'h0);
    ce_i <= 1'b1;
    wait_cyc(3);
    chk("lockout 5000", 32'(input_lockout_o), 32'h1);
    vin_mv_i <= 16'h2ee0;
    iin_a_i <= 16'h0033;
    wait_cyc(3);
    chk("oc 51", 32'(input_overcurrent_o), 32'h1);
    iin_a_i <= 16'h0028;
    wait_cyc(3);
    chk("oc 40", 32'(input_overcurrent_o), 32'h0);
    wr(supply_limit_pkg::IDX_OC_THRESH, 16'h001e);
    wait_cyc(3);
    chk("oc pending", 32'(input_overcurrent_o), 32'h0);
    wr(supply_limit_pkg::IDX_COMMIT, 16'h0);
    wait_cyc(3);
    chk("oc applied", 32'(input_overcurrent_o), 32'h1);
    iin_a_i <= 16'h0;
  endtask : t_gate
  task t_seq;
    wr(supply_limit_pkg::IDX_OFF_DELAY, 16'h1);
    wr(supply_limit_pkg::IDX_RISE_TIME, 16'h0);
    wr(supply_limit_pkg::IDX_VOUT_TARGET, 16'h0100);
    // The target changed, so the commit is issued again.
    wr(supply_limit_pkg::IDX_COMMIT, 16'h0);
    wr(supply_limit_pkg::IDX_CONTROL, 16'h1);
    wait_cyc(5);
    chk("rail on", 32'(rail_on_o), 32'h1);
    wait_cyc(19900);
    chk("ramp in delay", ramp_ref_o, 32'h0);
    wait_cyc(200);
    chk("ramp at target", ramp_ref_o, 32'h0100);
    wr(supply_limit_pkg::IDX_CONTROL, 16'h0);
    wait_cyc(950);
    chk("rail in off delay", 32'(rail_on_o), 32'h1);
    wait_cyc(100);
    chk("rail off", 32'(rail_on_o), 32'h0);
    wait_cyc(3);
    chk("ramp off", ramp_ref_o, 32'h0);
  endtask : t_seq
  // The longest scenario waits about 21000 cycles.
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    wait_cyc(3);
    rst_b_i <= 1'b1;
    t_reset();
    t_page();
    t_gate();
    t_seq();
    stop_test();
  end
endmodule : supply_limit_sequencing_regs_bench

// File: verification/supply_limit_sequencing_regs_sva.sv
// Checker of bus timing and output relations of the register bank.
module slsr_chk (
  input wire logic core_clk_i, // clock
  input wire logic rst_b_i, // reset, active low
  input wire logic ce_i, // clock enable
  input wire logic [9:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  input wire logic [31:0] avs_readdata, // read data
  input wire logic avs_waitrequest, // wait
  input wire logic [15:0] vin_mv_i, // input voltage
  input wire logic [15:0] iin_a_i, // input current
  input wire logic input_lockout_o, // lockout
  input wire logic input_overcurrent_o, // overcurrent
  input wire logic [1:0] rail_on_o, // rails active
  input wire logic [31:0] ramp_ref_o // ramp references
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic rq = avs_read | avs_write;
  default clocking @(posedge core_clk_i); endclocking
  // A frozen clock enable stalls the bus, so timing checks pause with it.
  default disable iff (!rst_b_i || !ce_i);
  a_wait_one: assert property (rq && avs_waitrequest |=> !avs_waitrequest)
    else $error("access took more than one wait state");
  a_idle_free: assert property (!rq |-> !avs_waitrequest)
    else $error("waitrequest high while idle");
  a_wait_first: assert property ($rose(rq) |-> avs_waitrequest)
    else $error("new access answered without a wait state");
  a_rd_upper: assert property (avs_readdata[31:16] == 16'h0)
    else $error("upper read data not zero");
  a_unmapped_zero: assert property (avs_read && avs_waitrequest &&
    avs_address[9:2] < 8'h59 |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_off_zero0: assert property (!rail_on_o[0] [*2] |->
    ramp_ref_o[15:0] == 16'h0)
    else $error("ramp reference of output 0 not zero while off");
  a_off_zero1: assert property (!rail_on_o[1] [*2] |->
    ramp_ref_o[31:16] == 16'h0)
    else $error("ramp reference of output 1 not zero while off");
  a_delay_hold: assert property ($rose(rail_on_o[0]) |=>
    (ramp_ref_o[15:0] == 16'h0) [*8])
    else $error("ramp started before the on delay");
  a_oc_zero: assert property (iin_a_i == 16'h0 |=>
    !input_overcurrent_o)
    else $error("overcurrent with zero input current");
endmodule : slsr_chk

bind supply_limit_sequencing_regs slsr_chk chk_u (
  .core_clk_i(core_clk_i),
  .rst_b_i(rst_b_i),
  .ce_i(ce_i),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .vin_mv_i(vin_mv_i),
  .iin_a_i(iin_a_i),
  .input_lockout_o(input_lockout_o),
  .input_overcurrent_o(input_overcurrent_o),
  .rail_on_o(rail_on_o),
  .ramp_ref_o(ramp_ref_o)
);
